// file: phy_strap_pkg.sv
// constants and types shared by the strap latch and mac port
package phy_strap_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int STRAP_W = 10;
  localparam int ADDR_W  = 5;
  localparam int DATA_W  = 16;
  localparam int NIB_W   = 4;
  localparam int DIB_W   = 2;
  localparam int FRM_W   = 16;
  localparam int CNT_W   = 4;
  // ---------------------------------------------------------------
  // strap pin positions
  // ---------------------------------------------------------------
  localparam int IDX_ADDR0  = 0;
  localparam int IDX_SEL0   = 3;
  localparam int IDX_ISO    = 6;
  localparam int IDX_SPEED  = 7;
  localparam int IDX_DUPLEX = 8;
  localparam int IDX_AN     = 9;
  localparam logic [STRAP_W-1:0] STRAP_PULL_UP = 10'h381;
  localparam logic [1:0] ADDR_UPPER = 2'h0;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_BCTL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_ADV  = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_STAT = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_FRM  = 5'h11;
  localparam int BCTL_SPEED  = 13;
  localparam int BCTL_AN     = 12;
  localparam int BCTL_ISO    = 10;
  localparam int BCTL_DUPLEX = 8;
  localparam int ADV_100FD   = 8;
  localparam int ADV_100HD   = 7;
  localparam int ADV_10FD    = 6;
  localparam int ADV_10HD    = 5;
  localparam int STAT_MODE0  = 8;
  localparam logic [DATA_W-1:0] BCTL_RST     = 16'h0000;
  localparam logic [DATA_W-1:0] ADV_SELECTOR = 16'h0001;
  // ---------------------------------------------------------------
  // sampling window after reset release, in clk_sys cycles
  // ---------------------------------------------------------------
  localparam int SETTLE_CYCLES = 4;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_MII  = 3'b000,
    MODE_RMII = 3'b001,
    MODE_LOOP = 3'b100
  } mode_t;
  typedef enum logic {
    ST_SAMPLE = 1'b0,
    ST_RUN    = 1'b1
  } cfg_st_t;
endpackage

// file: phy_strap_mac_port.sv
// strap capture, control registers and mii/rmii data port framing
//
// What this block does
// - mii receive nibble follows the link clock; data valid only with rx_dv high.
// - rmii sends two receive bits per reference clock while crs_dv is high.
// - transmit nibble is ignored in any cycle with tx_en low.
// - rmii takes two transmit bits per reference clock while tx_en is high.
// - management address comes from three strap pins, values zero to seven.
// - pulls alone give management address 00001.
// - upper two management address bits are always zero.
// - interface strap: 000 mii, 001 rmii, 100 pcs loopback, others reserved.
// - isolate strap loads control bit 10; high isolates the receive outputs only, transmit still passes to the line.
// - speed strap loads control bit 13; high means 100 mbps.
// - speed strap also sets advertised speed capability.
// - duplex strap loads control bit 8; high means half duplex.
// - autoneg strap loads control bit 12; high enables auto-negotiation.
// - strap pins are pulled inputs during reset, driven outputs afterwards.
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module phy_strap_mac_port
  import phy_strap_pkg::*;
#(
  parameter int SETTLE = phy_strap_pkg::SETTLE_CYCLES
) (
  input  wire  logic                                  clk_sys,
  input  wire  logic                                  rstn,
  input  wire  logic                                  ce,
  input  wire  logic                                  lnk_clk,
  input  wire  logic [phy_strap_pkg::ADDR_W-1:0]      reg_addr,
  input  wire  logic [phy_strap_pkg::DATA_W-1:0]      reg_wdata,
  input  wire  logic                                  reg_wr,
  input  wire  logic                                  reg_rd,
  output logic       [phy_strap_pkg::DATA_W-1:0]      reg_rdata,
  input  wire  logic [phy_strap_pkg::STRAP_W-1:0]     strap_in,
  output logic       [phy_strap_pkg::STRAP_W-1:0]     strap_out,
  output logic       [phy_strap_pkg::STRAP_W-1:0]     strap_oe,
  output logic       [phy_strap_pkg::STRAP_W-1:0]     strap_pull_up,
  output logic                                        strap_pull_en,
  input  wire  logic [phy_strap_pkg::STRAP_W-1:0]     pin_func,
  output logic       [phy_strap_pkg::ADDR_W-1:0]      mgmt_addr,
  input  wire  logic [phy_strap_pkg::NIB_W-1:0]       rec_data,
  input  wire  logic                                  rec_valid,
  output logic       [phy_strap_pkg::NIB_W-1:0]       rxd,
  output logic                                        rx_dv,
  input  wire  logic [phy_strap_pkg::NIB_W-1:0]       txd,
  input  wire  logic                                  tx_en,
  output logic       [phy_strap_pkg::NIB_W-1:0]       line_tx_data,
  output logic                                        line_tx_valid
);

  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [STRAP_W-1:0] strap_s1;
    logic [STRAP_W-1:0] strap_s2;
    logic [CNT_W-1:0]   cnt;
    cfg_st_t            st;
    logic [ADDR_W-1:0]  maddr;
    mode_t              mode;
    logic [DATA_W-1:0]  bctl;
    logic [DATA_W-1:0]  adv;
    logic [DATA_W-1:0]  rdata;
    logic [STRAP_W-1:0] sout;
    logic [STRAP_W-1:0] soe;
    logic [STRAP_W-1:0] pull_up;
    logic               pull_en;
    logic               tog_s1;
    logic               tog_s2;
    logic               tog_s3;
    logic [FRM_W-1:0]   frames;
  } sys_state_t;

  typedef struct packed {
    logic               ce_s1;
    logic               ce_s2;
    logic [2:0]         mode_s1;
    logic [2:0]         mode_s2;
    logic               iso_s1;
    logic               iso_s2;
    logic [NIB_W-1:0]   rxd;
    logic               rx_dv;
    logic [NIB_W-1:0]   txd;
    logic               tx_vld;
    logic               tx_en_d;
    logic               tog;
  } lnk_state_t;

  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE - 1);

  sys_state_t s_q;
  sys_state_t s_d;
  lnk_state_t l_q;
  lnk_state_t l_d;

  // ---------------------------------------------------------------
  // strap decode
  // ---------------------------------------------------------------
  logic [2:0]        sel_raw;
  mode_t             sel_mode;
  logic [ADDR_W-1:0] addr_strap;
  logic [DATA_W-1:0] bctl_strap;
  logic [DATA_W-1:0] adv_strap;

  always_comb begin
    sel_raw = s_q.strap_s2[IDX_SEL0 +: 3];
    case (sel_raw)
      MODE_RMII: sel_mode = MODE_RMII;
      MODE_LOOP: sel_mode = MODE_LOOP;
      // reserved codes fall back to mii so the port stays usable
      default:   sel_mode = MODE_MII;
    endcase
    addr_strap = {ADDR_UPPER, s_q.strap_s2[IDX_ADDR0 +: 3]};
    bctl_strap = BCTL_RST;
    bctl_strap[BCTL_ISO]    = s_q.strap_s2[IDX_ISO];
    bctl_strap[BCTL_SPEED]  = s_q.strap_s2[IDX_SPEED];
    // register bit is 1 for full duplex, strap high asks for half
    bctl_strap[BCTL_DUPLEX] = ~s_q.strap_s2[IDX_DUPLEX];
    bctl_strap[BCTL_AN]     = s_q.strap_s2[IDX_AN];
    adv_strap = ADV_SELECTOR;
    adv_strap[ADV_10HD]  = 1'b1;
    adv_strap[ADV_10FD]  = 1'b1;
    adv_strap[ADV_100HD] = s_q.strap_s2[IDX_SPEED];
    adv_strap[ADV_100FD] = s_q.strap_s2[IDX_SPEED];
  end

  // ---------------------------------------------------------------
  // system domain: strap latch, registers, frame count
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (ce) begin
      s_d.strap_s1 = strap_in;
      s_d.strap_s2 = s_q.strap_s1;
      s_d.tog_s1   = l_q.tog;
      s_d.tog_s2   = s_q.tog_s1;
      s_d.tog_s3   = s_q.tog_s2;
      s_d.rdata    = '0;
      case (s_q.st)
        ST_SAMPLE: begin
          // pins still float on their pulls; keep re-sampling until settled
          s_d.maddr = addr_strap;
          s_d.mode  = sel_mode;
          s_d.bctl  = bctl_strap;
          s_d.adv   = adv_strap;
          s_d.cnt   = s_q.cnt + CNT_W'(1);
          if (s_q.cnt == SETTLE_LAST) begin
            s_d.st      = ST_RUN;
            s_d.pull_en = 1'b0;
          end
        end
        ST_RUN: begin
          s_d.soe  = '1;
          s_d.sout = pin_func;
          if (s_q.tog_s3 != s_q.tog_s2) begin
            s_d.frames = s_q.frames + FRM_W'(1);
          end
          if (reg_wr) begin
            case (reg_addr)
              OFS_BCTL: s_d.bctl = reg_wdata;
              OFS_ADV:  s_d.adv  = reg_wdata;
              default:  s_d.frames = s_d.frames;
            endcase
          end
        end
        default: s_d.st = ST_SAMPLE;
      endcase
      if (reg_rd) begin
        case (reg_addr)
          OFS_BCTL: s_d.rdata = s_q.bctl;
          OFS_ADV:  s_d.rdata = s_q.adv;
          OFS_STAT: s_d.rdata = {DATA_W'(s_q.mode) << STAT_MODE0} | DATA_W'(s_q.maddr);
          OFS_FRM:  s_d.rdata = s_q.frames;
          default:  s_d.rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_q         <= '0;
      s_q.st      <= ST_SAMPLE;
      s_q.mode    <= MODE_MII;
      s_q.bctl    <= BCTL_RST;
      s_q.adv     <= ADV_SELECTOR;
      s_q.soe     <= '0;
      s_q.pull_up <= STRAP_PULL_UP;
      s_q.pull_en <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // link domain: mii / rmii framing
  // ---------------------------------------------------------------
  mode_t lmode;

  always_comb begin
    lmode = mode_t'(l_q.mode_s2);
    l_d = l_q;
    l_d.ce_s1   = ce;
    l_d.ce_s2   = l_q.ce_s1;
    // mode and isolate are quasi-static after the latch, a level sync is enough
    l_d.mode_s1 = s_q.mode;
    l_d.mode_s2 = l_q.mode_s1;
    l_d.iso_s1  = s_q.bctl[BCTL_ISO];
    l_d.iso_s2  = l_q.iso_s1;
    if (l_q.ce_s2) begin
      l_d.tx_en_d = tx_en;
      l_d.tx_vld  = tx_en;
      if (tx_en) begin
        if (lmode == MODE_RMII) begin
          l_d.txd = {2'b00, txd[DIB_W-1:0]};
        end else begin
          l_d.txd = txd;
        end
      end
      if (l_q.tx_en_d && !tx_en) begin
        l_d.tog = ~l_q.tog;
      end
      l_d.rxd   = '0;
      l_d.rx_dv = 1'b0;
      if (!l_q.iso_s2) begin
        case (lmode)
          MODE_RMII: begin
            l_d.rx_dv = rec_valid;
            if (rec_valid) begin
              l_d.rxd = {2'b00, rec_data[DIB_W-1:0]};
            end
          end
          MODE_LOOP: begin
            // transmit path turned straight round to receive
            l_d.rx_dv = tx_en;
            if (tx_en) begin
              l_d.rxd = txd;
            end
          end
          default: begin
            l_d.rx_dv = rec_valid;
            if (rec_valid) begin
              l_d.rxd = rec_data;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge lnk_clk or negedge rstn) begin
    if (!rstn) begin
      l_q         <= '0;
      l_q.mode_s1 <= MODE_MII;
      l_q.mode_s2 <= MODE_MII;
    end else begin
      l_q <= l_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata     = s_q.rdata;
  assign strap_out     = s_q.sout;
  assign strap_oe      = s_q.soe;
  assign strap_pull_up = s_q.pull_up;
  assign strap_pull_en = s_q.pull_en;
  assign mgmt_addr     = s_q.maddr;
  assign rxd           = l_q.rxd;
  assign rx_dv         = l_q.rx_dv;
  assign line_tx_data  = l_q.txd;
  assign line_tx_valid = l_q.tx_vld;

  // ---------------------------------------------------------------
  // assertions, system domain
  // ---------------------------------------------------------------
  a_oe_off_sampling: assert property (@(posedge clk_sys) disable iff (!rstn)
    (s_q.st == ST_SAMPLE) |-> (s_q.soe == '0) && s_q.pull_en)
    else $error("strap pins driven while sampling");

  a_addr_upper_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_q.maddr[ADDR_W-1:3] == ADDR_UPPER)
    else $error("management address upper bits not zero");

  a_addr_latch: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ce && s_q.st == ST_SAMPLE && s_q.cnt == SETTLE_LAST)
      |=> (s_q.st == ST_RUN) && (s_q.maddr[2:0] == $past(s_q.strap_s2[IDX_ADDR0 +: 3])))
    else $error("management address not taken from straps");

  // the release edge itself still leaves the flops in reset, so start one edge later
  a_bctl_strap_load: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ce && s_q.st == ST_SAMPLE && s_q.cnt != '0)
      |=> s_q.bctl[BCTL_SPEED] == $past(s_q.strap_s2[IDX_SPEED])
          && s_q.bctl[BCTL_ISO] == $past(s_q.strap_s2[IDX_ISO])
          && s_q.bctl[BCTL_DUPLEX] == !$past(s_q.strap_s2[IDX_DUPLEX])
          && s_q.bctl[BCTL_AN] == $past(s_q.strap_s2[IDX_AN]))
    else $error("control bits do not follow straps");

  a_adv_speed: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ce && s_q.st == ST_SAMPLE && s_q.cnt != '0)
      |=> s_q.adv[ADV_100HD] == $past(s_q.strap_s2[IDX_SPEED]) && s_q.adv[ADV_10HD])
    else $error("advertised speed does not follow strap");

  a_straps_frozen: assert property (@(posedge clk_sys) disable iff (!rstn)
    (s_q.st == ST_RUN) |=> (s_q.st == ST_RUN) && $stable(s_q.maddr) && $stable(s_q.mode))
    else $error("latched strap values changed after release");

  a_mode_legal: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_q.mode inside {MODE_MII, MODE_RMII, MODE_LOOP})
    else $error("interface mode holds a reserved code");

  a_pins_driven_run: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ce && s_q.st == ST_RUN) |=> (s_q.soe == '1) && !s_q.pull_en)
    else $error("strap pins not driven after release");

  a_pins_follow_func: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ce && s_q.st == ST_RUN) |=> s_q.sout == $past(pin_func))
    else $error("strap pins do not carry their normal function");

  a_freeze_before_oe: assert property (@(posedge clk_sys) disable iff (!rstn)
    (s_q.soe != '0) |-> (s_q.st == ST_RUN))
    else $error("pin drivers on before straps frozen");

  a_ce_freeze: assert property (@(posedge clk_sys) disable iff (!rstn)
    !ce |=> $stable(s_q))
    else $error("system state moved with clock enable low");

  // ---------------------------------------------------------------
  // assertions, link domain
  // ---------------------------------------------------------------
  a_rx_dv_gating: assert property (@(posedge lnk_clk) disable iff (!rstn)
    !l_q.rx_dv |-> (l_q.rxd == '0))
    else $error("receive data moves without rx_dv");

  a_rmii_rx_dibit: assert property (@(posedge lnk_clk) disable iff (!rstn)
    (l_q.ce_s2 && lmode == MODE_RMII && !l_q.iso_s2 && rec_valid)
      |=> l_q.rx_dv && l_q.rxd == {2'b00, $past(rec_data[DIB_W-1:0])})
    else $error("rmii receive dibit not sent");

  a_tx_idle_ignored: assert property (@(posedge lnk_clk) disable iff (!rstn)
    (l_q.ce_s2 && !tx_en) |=> !l_q.tx_vld && $stable(l_q.txd))
    else $error("transmit nibble taken without tx_en");

  a_rmii_tx_dibit: assert property (@(posedge lnk_clk) disable iff (!rstn)
    (l_q.ce_s2 && lmode == MODE_RMII && tx_en)
      |=> l_q.tx_vld && l_q.txd == {2'b00, $past(txd[DIB_W-1:0])})
    else $error("rmii transmit dibit not accepted");

  a_mii_rx_nibble: assert property (@(posedge lnk_clk) disable iff (!rstn)
    (l_q.ce_s2 && lmode == MODE_MII && !l_q.iso_s2 && rec_valid)
      |=> l_q.rx_dv && l_q.rxd == $past(rec_data))
    else $error("mii receive nibble not sent");

  a_mii_tx_nibble: assert property (@(posedge lnk_clk) disable iff (!rstn)
    (l_q.ce_s2 && lmode != MODE_RMII && tx_en) |=> l_q.tx_vld && l_q.txd == $past(txd))
    else $error("mii transmit nibble not accepted");

  a_loop_turn: assert property (@(posedge lnk_clk) disable iff (!rstn)
    (l_q.ce_s2 && lmode == MODE_LOOP && !l_q.iso_s2) |=> l_q.rx_dv == $past(tx_en))
    else $error("loopback does not return transmit enable");

  a_rx_isolate: assert property (@(posedge lnk_clk) disable iff (!rstn)
    (l_q.ce_s2 && l_q.iso_s2) |=> !l_q.rx_dv && (l_q.rxd == '0))
    else $error("receive outputs move while isolated");

  c_strap_release: cover property (@(posedge clk_sys) disable iff (!rstn)
    s_q.st == ST_SAMPLE ##1 s_q.st == ST_RUN);
  c_frame_counted: cover property (@(posedge clk_sys) disable iff (!rstn)
    s_q.tog_s3 != s_q.tog_s2);
  c_rmii_receive: cover property (@(posedge lnk_clk) disable iff (!rstn)
    lmode == MODE_RMII && l_q.rx_dv);
  c_loopback: cover property (@(posedge lnk_clk) disable iff (!rstn)
    lmode == MODE_LOOP && l_q.rx_dv && l_q.tx_vld);
  c_ce_frozen: cover property (@(posedge clk_sys) disable iff (!rstn)
    !ce && s_q.st == ST_RUN);

endmodule

// file: mac_model.sv
// behavioural mac on the mii/rmii side of the port
`timescale 1ns/1ps
module mac_model
  import phy_strap_pkg::*;
(
  input  wire logic                              lnk_clk,
  input  wire logic [phy_strap_pkg::NIB_W-1:0]   rxd,
  input  wire logic                              rx_dv,
  output logic      [phy_strap_pkg::NIB_W-1:0]   txd,
  output logic                                   tx_en
);
  logic [NIB_W-1:0] rx_last = 4'h0;
  int               rx_cnt  = 0;
  initial begin
    txd   = 4'h0;
    tx_en = 1'b0;
  end
  // ---------------------------------------------------------------
  // receive: nibble taken only with rx_dv high
  // ---------------------------------------------------------------
  always @(posedge lnk_clk) begin
    if (rx_dv === 1'b1) begin
      rx_last <= rxd;
      rx_cnt  <= rx_cnt + 1;
    end
  end
  // ---------------------------------------------------------------
  // transmit: idle bus carries inverted data so a leaky gate shows
  // ---------------------------------------------------------------
  task automatic send(input logic [NIB_W-1:0] d, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge lnk_clk);
      tx_en <= 1'b1;
      txd   <= d + i[3:0];
    end
    @(posedge lnk_clk);
    tx_en <= 1'b0;
    txd   <= ~(d + n[3:0] - 4'h1);
  endtask
endmodule

// file: phy_strap_mac_port_tb.sv
// self-checking bench for strap capture and the mac data port
`timescale 1ns/1ps
module phy_strap_mac_port_tb;
  import phy_strap_pkg::*;
  logic               clk_sys   = 1'b0;
  logic               lnk_clk   = 1'b0;
  logic               rstn      = 1'b0;
  logic               ce        = 1'b1;
  logic [ADDR_W-1:0]  reg_addr  = 5'h00;
  logic [DATA_W-1:0]  reg_wdata = 16'h0000;
  logic               reg_wr    = 1'b0;
  logic               reg_rd    = 1'b0;
  logic [DATA_W-1:0]  reg_rdata;
  logic [STRAP_W-1:0] strap_in  = STRAP_PULL_UP;
  logic [STRAP_W-1:0] strap_out, strap_oe, strap_pull_up;
  logic               strap_pull_en;
  logic [STRAP_W-1:0] pin_func  = 10'h2c5;
  logic [ADDR_W-1:0]  mgmt_addr;
  logic [NIB_W-1:0]   rec_data  = 4'h0;
  logic               rec_valid = 1'b0;
  logic [NIB_W-1:0]   rxd, txd, line_tx_data, tx_last;
  logic               rx_dv, tx_en, line_tx_valid;
  int                 err_total = 0;
  int                 tests_run = 0;
  int                 tx_n      = 0;
  logic [STRAP_W-1:0] straps [4] = '{10'h381, 10'h00f, 10'h2a6, 10'h150};

  always #2 clk_sys = ~clk_sys;
  always #16 lnk_clk = ~lnk_clk;

  phy_strap_mac_port DUT (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .lnk_clk(lnk_clk),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .strap_in(strap_in), .strap_out(strap_out), .strap_oe(strap_oe),
    .strap_pull_up(strap_pull_up), .strap_pull_en(strap_pull_en), .pin_func(pin_func),
    .mgmt_addr(mgmt_addr), .rec_data(rec_data), .rec_valid(rec_valid), .rxd(rxd),
    .rx_dv(rx_dv), .txd(txd), .tx_en(tx_en), .line_tx_data(line_tx_data),
    .line_tx_valid(line_tx_valid));
  mac_model mac (.lnk_clk(lnk_clk), .rxd(rxd), .rx_dv(rx_dv), .txd(txd), .tx_en(tx_en));

  always @(posedge lnk_clk) begin
    if (line_tx_valid === 1'b1) begin
      tx_n    <= tx_n + 1;
      tx_last <= line_tx_data;
    end
  end
  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask
  task automatic do_reset(input logic [STRAP_W-1:0] s);
    @(posedge clk_sys);
    rstn     <= 1'b0;
    strap_in <= s;
    repeat (8) @(posedge clk_sys);
    check(strap_oe, 16'h0000);
    check(strap_pull_en, 16'h0001);
    check(strap_pull_up, STRAP_PULL_UP);
    rstn <= 1'b1;
    repeat (30) @(posedge clk_sys);
    check(strap_oe, 16'h03ff);
    check(strap_pull_en, 16'h0000);
    check(strap_out, pin_func);
  endtask
  task automatic check_regs(input logic [STRAP_W-1:0] s);
    logic [2:0]        md;
    logic [DATA_W-1:0] ctl;
    logic [DATA_W-1:0] adv;
    md  = (s[5:3] == 3'b001 || s[5:3] == 3'b100) ? s[5:3] : 3'b000;
    ctl = 16'h0000;
    ctl[BCTL_SPEED]  = s[IDX_SPEED];
    ctl[BCTL_AN]     = s[IDX_AN];
    ctl[BCTL_ISO]    = s[IDX_ISO];
    ctl[BCTL_DUPLEX] = ~s[IDX_DUPLEX];
    adv = ADV_SELECTOR;
    adv[ADV_10FD]  = 1'b1;
    adv[ADV_10HD]  = 1'b1;
    adv[ADV_100FD] = s[IDX_SPEED];
    adv[ADV_100HD] = s[IDX_SPEED];
    // pins now moved: captured values must not follow them
    strap_in <= ~s;
    rd_chk(OFS_BCTL, ctl);
    rd_chk(OFS_ADV, adv);
    rd_chk(OFS_STAT, {5'h00, md, 3'h0, ADDR_UPPER, s[2:0]});
    check(mgmt_addr, {ADDR_UPPER, s[2:0]});
  endtask
  task automatic traffic(input logic [STRAP_W-1:0] s);
    logic [2:0] md;
    int         r0;
    int         t0;
    md = s[5:3];
    r0 = mac.rx_cnt;
    t0 = tx_n;
    for (int i = 0; i < 3; i++) begin
      @(posedge lnk_clk);
      rec_valid <= 1'b1;
      rec_data  <= 4'h9 + i[3:0];
    end
    @(posedge lnk_clk);
    rec_valid <= 1'b0;
    rec_data  <= 4'h6;
    repeat (4) @(posedge lnk_clk);
    if (md != 3'b100) begin
      check(mac.rx_cnt - r0, s[IDX_ISO] ? 16'h0 : 16'h3);
      if (!s[IDX_ISO]) check(mac.rx_last, md == 3'b001 ? 4'h3 : 4'hb);
    end
    r0 = mac.rx_cnt;
    mac.send(4'hc, 2);
    repeat (6) @(posedge lnk_clk);
    if (md == 3'b100) begin
      check(mac.rx_cnt - r0, 16'h2);
      check(mac.rx_last, 4'hd);
    end else begin
      check(tx_n - t0, 16'h2);
      check(tx_last, md == 3'b001 ? 4'h1 : 4'hd);
      rd_chk(OFS_FRM, 16'h0001);
    end
  endtask
  task automatic tally_and_finish;
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    for (int k = 0; k < 4; k++) begin
      do_reset(straps[k]);
      check_regs(straps[k]);
      traffic(straps[k]);
    end
    wr(OFS_BCTL, 16'h2100);
    rd_chk(OFS_BCTL, 16'h2100);
    wr(OFS_STAT, 16'hffff);
    rd_chk(OFS_STAT, 16'h0000);
    rd_chk(5'h1f, 16'h0000);
    // clock enable low: the write must leave no trace
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(OFS_BCTL, 16'h0000);
    @(posedge clk_sys);
    ce <= 1'b1;
    rd_chk(OFS_BCTL, 16'h2100);
    tally_and_finish();
  end
  initial begin
    #100000;
    err_total++;
    tally_and_finish();
  end
endmodule
